// ==== dct_pkg.sv ====
package dct_pkg;

  // timer mode register field positions
  localparam int T0_MODE_LSB = 0;
  localparam int T0_COUNTER_SELECT_BIT = 2;
  localparam int T0_GATE_SELECT_BIT = 3;
  localparam int T1_MODE_LSB = 4;
  localparam int T1_COUNTER_SELECT_BIT = 6;
  localparam int T1_GATE_SELECT_BIT = 7;
  localparam int MODE_WIDTH = 2;

  // flag write data bit positions
  localparam int FLAG_T0_BIT = 0;
  localparam int FLAG_T1_BIT = 1;

  typedef enum logic [1:0] {
    DCT_MODE_13BIT = 2'h0,
    DCT_MODE_16BIT = 2'h1,
    DCT_MODE_RELOAD = 2'h2,
    DCT_MODE_SPLIT = 2'h3
  } dct_mode_type;

  // count byte select for software writes
  localparam logic [1:0] SEL_T0_LOW = 2'h0;
  localparam logic [1:0] SEL_T0_HIGH = 2'h1;
  localparam logic [1:0] SEL_T1_LOW = 2'h2;
  localparam logic [1:0] SEL_T1_HIGH = 2'h3;

  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic PIN_IDLE = 1'b1;

  // 13-bit mode keeps five count bits in the low byte
  localparam int MODE0_LOW_BITS = 5;

  // prescaled clock divisors, one per clock divider select code
  localparam int PRESCALE_WIDTH = 6;
  localparam logic [5:0] PRESCALE_DIV_SEL0 = 6'h0c;
  localparam logic [5:0] PRESCALE_DIV_SEL1 = 6'h04;
  localparam logic [5:0] PRESCALE_DIV_SEL2 = 6'h30;
  localparam logic [5:0] PRESCALE_DIV_SEL3 = 6'h08;

  typedef struct packed {
    logic ovf;
    logic [7:0] high;
    logic [7:0] low;
  } dct_count_type;

  typedef struct packed {
    logic level;
    logic fall;
  } dct_pin_type;

  typedef struct packed {
    logic [7:0] t0_low;
    logic [7:0] t0_high;
    logic [7:0] t1_low;
    logic [7:0] t1_high;
    logic t0_flag;
    logic t1_flag;
    logic t0_irq;
    logic t1_irq;
    logic t1_baud;
  } dct_state_type;

endpackage

// ==== dct_pin_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module dct_pin_sync
(
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_pin,
  output dct_pkg::dct_pin_type o_pin
);

  typedef struct packed {
    logic meta;
    logic stable;
    logic previous;
  } dct_sync_state_type;

  dct_sync_state_type state;
  dct_sync_state_type next_state;

  always_comb
  begin
    next_state.meta = i_pin;
    next_state.stable = state.meta;
    next_state.previous = state.stable;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      state <= {3{dct_pkg::PIN_IDLE}};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign o_pin.level = state.stable;
  assign o_pin.fall = state.previous & ~state.stable;

endmodule
`default_nettype wire

// ==== dct_prescaler.sv ====
`timescale 1ns/10ps
`default_nettype none
module dct_prescaler
(
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [1:0] i_clock_divider_select,
  output logic o_tick
);

  typedef struct packed {
    logic [dct_pkg::PRESCALE_WIDTH-1:0] count;
    logic tick;
  } dct_prescale_state_type;

  dct_prescale_state_type state;
  dct_prescale_state_type next_state;
  logic [dct_pkg::PRESCALE_WIDTH-1:0] last;

  always_comb
  begin
    case (i_clock_divider_select)
      2'h0: last = dct_pkg::PRESCALE_DIV_SEL0 - 6'h01;
      2'h1: last = dct_pkg::PRESCALE_DIV_SEL1 - 6'h01;
      2'h2: last = dct_pkg::PRESCALE_DIV_SEL2 - 6'h01;
      default: last = dct_pkg::PRESCALE_DIV_SEL3 - 6'h01;
    endcase
    next_state = state;
    // wrap also when the select shrinks below the running count
    if (state.count >= last)
    begin
      next_state.count = '0;
      next_state.tick = 1'b1;
    end
    else
    begin
      next_state.count = state.count + 6'h01;
      next_state.tick = 1'b0;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign o_tick = state.tick;

endmodule
`default_nettype wire

// ==== dct_timers.sv ====
`timescale 1ns/10ps
`default_nettype none
module dct_timers
(
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [7:0] i_timer_mode_reg,
  input wire logic i_timer0_run,
  input wire logic i_timer1_run,
  input wire logic i_timer0_sysclk_select,
  input wire logic i_timer1_sysclk_select,
  input wire logic [1:0] i_clock_divider_select,
  input wire logic i_timer0_gate_polarity,
  input wire logic i_timer1_gate_polarity,
  input wire logic i_timer0_irq_enable,
  input wire logic i_timer1_irq_enable,
  input wire logic i_timer0_count_pin,
  input wire logic i_timer1_count_pin,
  input wire logic i_timer0_gate_input,
  input wire logic i_timer1_gate_input,
  input wire logic i_count_write,
  input wire logic [1:0] i_count_write_select,
  input wire logic [7:0] i_count_write_data,
  input wire logic i_flag_write,
  input wire logic [1:0] i_flag_write_data,
  input wire logic i_timer0_vector_ack,
  input wire logic i_timer1_vector_ack,
  output logic [7:0] o_timer0_low_byte,
  output logic [7:0] o_timer0_high_byte,
  output logic [7:0] o_timer1_low_byte,
  output logic [7:0] o_timer1_high_byte,
  output logic o_timer0_overflow_flag,
  output logic o_timer1_overflow_flag,
  output logic o_timer0_irq,
  output logic o_timer1_irq,
  output logic o_timer1_baud_tick
);

  dct_pkg::dct_state_type state;
  dct_pkg::dct_state_type next_state;

  dct_pkg::dct_pin_type count_pin0;
  dct_pkg::dct_pin_type count_pin1;
  dct_pkg::dct_pin_type gate_pin0;
  dct_pkg::dct_pin_type gate_pin1;
  logic prescale_tick;

  dct_pkg::dct_mode_type mode0;
  dct_pkg::dct_mode_type mode1;
  logic counter_select0;
  logic counter_select1;
  logic gate_select0;
  logic gate_select1;
  logic internal_tick0;
  logic internal_tick1;
  logic gate_ok0;
  logic gate_ok1;
  logic split;
  logic enable0;
  logic enable1;
  logic enable_split_high;
  dct_pkg::dct_count_type step0;
  dct_pkg::dct_count_type step1;
  logic [8:0] split_high_sum;
  logic set_flag0;
  logic set_flag1;
  logic clear_flag0;
  logic clear_flag1;

  dct_pin_sync u_count_pin0
  (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_pin(i_timer0_count_pin),
    .o_pin(count_pin0)
  );

  dct_pin_sync u_count_pin1
  (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_pin(i_timer1_count_pin),
    .o_pin(count_pin1)
  );

  dct_pin_sync u_gate_pin0
  (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_pin(i_timer0_gate_input),
    .o_pin(gate_pin0)
  );

  dct_pin_sync u_gate_pin1
  (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_pin(i_timer1_gate_input),
    .o_pin(gate_pin1)
  );

  dct_prescaler u_prescaler
  (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_clock_divider_select(i_clock_divider_select),
    .o_tick(prescale_tick)
  );

  // one count step of a timer in a given mode; called every cycle, result used only when enabled
  function automatic dct_pkg::dct_count_type advance
  (
    input dct_pkg::dct_mode_type mode,
    input logic [7:0] low,
    input logic [7:0] high
  );
    dct_pkg::dct_count_type result;
    logic [12:0] count13;
    logic [15:0] count16;
    logic [7:0] count8;
    result.ovf = 1'b0;
    result.low = low;
    result.high = high;
    count13 = {high, low[dct_pkg::MODE0_LOW_BITS-1:0]} + 13'h0001;
    count16 = {high, low} + 16'h0001;
    count8 = low + 8'h01;
    case (mode)
      dct_pkg::DCT_MODE_13BIT:
      begin
        // upper three low-byte bits are left as they are
        result.high = count13[12:dct_pkg::MODE0_LOW_BITS];
        result.low = {low[7:dct_pkg::MODE0_LOW_BITS], count13[dct_pkg::MODE0_LOW_BITS-1:0]};
        result.ovf = &{high, low[dct_pkg::MODE0_LOW_BITS-1:0]};
      end
      dct_pkg::DCT_MODE_16BIT:
      begin
        result.high = count16[15:8];
        result.low = count16[7:0];
        result.ovf = &{high, low};
      end
      dct_pkg::DCT_MODE_RELOAD:
      begin
        if (&low)
        begin
          result.low = high;
          result.ovf = 1'b1;
        end
        else
        begin
          result.low = count8;
        end
      end
      default:
      begin
        result.low = count8;
        result.ovf = &low;
      end
    endcase
    return result;
  endfunction

  always_comb
  begin
    mode0 = dct_pkg::dct_mode_type'(i_timer_mode_reg[dct_pkg::T0_MODE_LSB +: dct_pkg::MODE_WIDTH]);
    mode1 = dct_pkg::dct_mode_type'(i_timer_mode_reg[dct_pkg::T1_MODE_LSB +: dct_pkg::MODE_WIDTH]);
    counter_select0 = i_timer_mode_reg[dct_pkg::T0_COUNTER_SELECT_BIT];
    counter_select1 = i_timer_mode_reg[dct_pkg::T1_COUNTER_SELECT_BIT];
    gate_select0 = i_timer_mode_reg[dct_pkg::T0_GATE_SELECT_BIT];
    gate_select1 = i_timer_mode_reg[dct_pkg::T1_GATE_SELECT_BIT];
    split = (mode0 == dct_pkg::DCT_MODE_SPLIT);

    internal_tick0 = i_timer0_sysclk_select ? 1'b1 : prescale_tick;
    internal_tick1 = i_timer1_sysclk_select ? 1'b1 : prescale_tick;

    gate_ok0 = ~gate_select0 | (gate_pin0.level == i_timer0_gate_polarity);
    gate_ok1 = ~gate_select1 | (gate_pin1.level == i_timer1_gate_polarity);

    // the run bit only enables; the count is never touched by it
    enable0 = i_timer0_run & gate_ok0 & (counter_select0 ? count_pin0.fall : internal_tick0);

    if (mode1 == dct_pkg::DCT_MODE_SPLIT)
    begin
      enable1 = 1'b0;
    end
    else if (split)
    begin
      enable1 = internal_tick1;
    end
    else
    begin
      enable1 = i_timer1_run & gate_ok1 & (counter_select1 ? count_pin1.fall : internal_tick1);
    end

    enable_split_high = split & i_timer1_run & internal_tick0;

    step0 = advance(mode0, state.t0_low, state.t0_high);
    step1 = advance(mode1, state.t1_low, state.t1_high);
    split_high_sum = {1'b0, state.t0_high} + 9'h001;

    next_state = state;
    next_state.t1_baud = 1'b0;

    if (enable0)
    begin
      next_state.t0_low = step0.low;
      if (!split)
      begin
        next_state.t0_high = step0.high;
      end
    end
    if (enable_split_high)
    begin
      next_state.t0_high = split_high_sum[7:0];
    end
    if (enable1)
    begin
      next_state.t1_low = step1.low;
      next_state.t1_high = step1.high;
      next_state.t1_baud = step1.ovf;
    end

    // software byte writes take priority over a same-cycle count step
    if (i_count_write)
    begin
      if (i_count_write_select == dct_pkg::SEL_T0_LOW)
      begin
        next_state.t0_low = i_count_write_data;
      end
      else if (i_count_write_select == dct_pkg::SEL_T0_HIGH)
      begin
        next_state.t0_high = i_count_write_data;
      end
      else if (i_count_write_select == dct_pkg::SEL_T1_LOW)
      begin
        next_state.t1_low = i_count_write_data;
      end
      else
      begin
        next_state.t1_high = i_count_write_data;
      end
    end

    set_flag0 = enable0 & step0.ovf;
    if (split)
    begin
      set_flag1 = enable_split_high & split_high_sum[8];
    end
    else
    begin
      set_flag1 = enable1 & step1.ovf;
    end
    clear_flag0 = (i_flag_write & ~i_flag_write_data[dct_pkg::FLAG_T0_BIT]) | i_timer0_vector_ack;
    clear_flag1 = (i_flag_write & ~i_flag_write_data[dct_pkg::FLAG_T1_BIT]) | i_timer1_vector_ack;

    // a hardware set in the clearing cycle wins
    if (set_flag0)
    begin
      next_state.t0_flag = 1'b1;
    end
    else if (clear_flag0)
    begin
      next_state.t0_flag = 1'b0;
    end
    if (set_flag1)
    begin
      next_state.t1_flag = 1'b1;
    end
    else if (clear_flag1)
    begin
      next_state.t1_flag = 1'b0;
    end

    next_state.t0_irq = next_state.t0_flag & i_timer0_irq_enable;
    next_state.t1_irq = next_state.t1_flag & i_timer1_irq_enable;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      state.t0_low <= dct_pkg::COUNT_RESET;
      state.t0_high <= dct_pkg::COUNT_RESET;
      state.t1_low <= dct_pkg::COUNT_RESET;
      state.t1_high <= dct_pkg::COUNT_RESET;
      state.t0_flag <= 1'b0;
      state.t1_flag <= 1'b0;
      state.t0_irq <= 1'b0;
      state.t1_irq <= 1'b0;
      state.t1_baud <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign o_timer0_low_byte = state.t0_low;
  assign o_timer0_high_byte = state.t0_high;
  assign o_timer1_low_byte = state.t1_low;
  assign o_timer1_high_byte = state.t1_high;
  assign o_timer0_overflow_flag = state.t0_flag;
  assign o_timer1_overflow_flag = state.t1_flag;
  assign o_timer0_irq = state.t0_irq;
  assign o_timer1_irq = state.t1_irq;
  assign o_timer1_baud_tick = state.t1_baud;

endmodule
`default_nettype wire

// ==== dct_pins_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module dct_pins_model
(
  input wire logic i_clock,
  input wire logic [1:0] i_fire,
  input wire logic [1:0] i_gate,
  output logic [1:0] o_pin,
  output logic [1:0] o_gate
);
  logic [1:0] low0 = 2'h0;
  logic [1:0] low1 = 2'h0;
  logic [1:0] gate_q = 2'h0;
  // a fired pin stays low three clocks, then idles high
  always @(posedge i_clock)
  begin
    gate_q <= i_gate;
    low0 <= i_fire[0] ? 2'h3 : low0 - {1'b0, low0 != 2'h0};
    low1 <= i_fire[1] ? 2'h3 : low1 - {1'b0, low1 != 2'h0};
  end
  assign o_pin = {low1 == 2'h0, low0 == 2'h0};
  assign o_gate = gate_q;
endmodule
`default_nettype wire

// ==== dct_timers_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module dct_timers_assertions
(
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [7:0] i_timer_mode_reg,
  input wire logic i_timer0_run,
  input wire logic i_timer0_sysclk_select,
  input wire logic i_timer0_irq_enable,
  input wire logic i_count_write,
  input wire logic [1:0] i_count_write_select,
  input wire logic [7:0] i_count_write_data,
  input wire logic i_timer0_vector_ack,
  input wire logic [7:0] o_timer0_low_byte,
  input wire logic [7:0] o_timer0_high_byte,
  input wire logic [7:0] o_timer1_low_byte,
  input wire logic [7:0] o_timer1_high_byte,
  input wire logic o_timer0_overflow_flag,
  input wire logic o_timer0_irq,
  input wire logic o_timer1_baud_tick
);
  wire logic [1:0] m0 = i_timer_mode_reg[1:0];
  wire logic [15:0] c0 = {o_timer0_high_byte, o_timer0_low_byte};
  // timer 0 free running on the system clock, no write in the way
  wire logic run0 = i_timer0_run && i_timer_mode_reg[3:2] == 2'h0 && i_timer0_sysclk_select && !i_count_write;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  low_write_a: assert property (i_count_write && i_count_write_select == dct_pkg::SEL_T0_LOW
    |=> o_timer0_low_byte == $past(i_count_write_data)) else $error("t0 low byte write lost");
  irq_gate_a: assert property (o_timer0_irq == (o_timer0_overflow_flag && $past(i_timer0_irq_enable)))
    else $error("t0 irq not flag and enable");
  stop_hold_a: assert property (!i_timer0_run && m0 != 2'h3 && !i_count_write |=> $stable(c0))
    else $error("t0 counted while stopped");
  t1_off_a: assert property (i_timer_mode_reg[5:4] == 2'h3 && !i_count_write
    |=> $stable({o_timer1_high_byte, o_timer1_low_byte}) && !o_timer1_baud_tick) else $error("t1 ran in mode 3");
  flag_ack_a: assert property (i_timer0_vector_ack && !i_timer0_run |=> !o_timer0_overflow_flag && !o_timer0_irq)
    else $error("t0 flag not cleared by ack");
  step_one_a: assert property (run0 && m0 == 2'h1 |=> c0 == $past(c0) + 16'h1)
    else $error("t0 16-bit step wrong");
  wrap_flag_a: assert property (run0 && m0 == 2'h1 && c0 == 16'hffff |=> o_timer0_overflow_flag)
    else $error("t0 16-bit wrap without flag");
  reload_copy_a: assert property (run0 && m0 == 2'h2 && o_timer0_low_byte == 8'hff
    |=> o_timer0_low_byte == o_timer0_high_byte && o_timer0_overflow_flag) else $error("t0 reload wrong");
  wrap_13_a: assert property (run0 && m0 == 2'h0 && o_timer0_high_byte == 8'hff && o_timer0_low_byte[4:0] == 5'h1f
    |=> c0[15:8] == 8'h00 && c0[4:0] == 5'h00 && o_timer0_overflow_flag) else $error("t0 13-bit wrap wrong");
  cover property (o_timer0_overflow_flag && o_timer0_irq);
  cover property (o_timer1_baud_tick);
  cover property (m0 == 2'h2 && o_timer0_overflow_flag);
endmodule
bind dct_timers dct_timers_assertions u_dct_timers_assertions
(
  .i_clock, .i_srst, .i_timer_mode_reg, .i_timer0_run, .i_timer0_sysclk_select, .i_timer0_irq_enable,
  .i_count_write, .i_count_write_select, .i_count_write_data, .i_timer0_vector_ack, .o_timer0_low_byte,
  .o_timer0_high_byte, .o_timer1_low_byte, .o_timer1_high_byte, .o_timer0_overflow_flag, .o_timer0_irq,
  .o_timer1_baud_tick
);
`default_nettype wire

// ==== dct_timers_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module dct_timers_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] timer_mode_reg = 8'h33;
  logic [1:0] run = 2'h0, sys = 2'h3, cds = 2'h0, pol = 2'h0, ie = 2'h0, fire = 2'h0, gate = 2'h0, ack = 2'h0;
  logic cw = 1'b0, fw = 1'b0;
  logic [1:0] sel = 2'h0, fwd = 2'h3, pin, gin;
  logic [7:0] wd = 8'h00, t0l, t0h, t1l, t1h;
  logic f0, f1, q0, q1, baud;
  int n_errors = 0, total_checks = 0;
  logic [5:0] div [4] = '{dct_pkg::PRESCALE_DIV_SEL0, dct_pkg::PRESCALE_DIV_SEL1,
    dct_pkg::PRESCALE_DIV_SEL2, dct_pkg::PRESCALE_DIV_SEL3};
  always #10 clk = ~clk;
  dct_pins_model u_dct_pins_model
  (
    .i_clock(clk), .i_fire(fire), .i_gate(gate), .o_pin(pin), .o_gate(gin)
  );
  dct_timers u_dct_timers
  (
    .i_clock(clk), .i_srst(srst), .i_timer_mode_reg(timer_mode_reg), .i_timer0_run(run[0]), .i_timer1_run(run[1]),
    .i_timer0_sysclk_select(sys[0]), .i_timer1_sysclk_select(sys[1]), .i_clock_divider_select(cds),
    .i_timer0_gate_polarity(pol[0]), .i_timer1_gate_polarity(pol[1]), .i_timer0_irq_enable(ie[0]),
    .i_timer1_irq_enable(ie[1]), .i_timer0_count_pin(pin[0]), .i_timer1_count_pin(pin[1]),
    .i_timer0_gate_input(gin[0]), .i_timer1_gate_input(gin[1]), .i_count_write(cw),
    .i_count_write_select(sel), .i_count_write_data(wd), .i_flag_write(fw), .i_flag_write_data(fwd),
    .i_timer0_vector_ack(ack[0]), .i_timer1_vector_ack(ack[1]), .o_timer0_low_byte(t0l),
    .o_timer0_high_byte(t0h), .o_timer1_low_byte(t1l), .o_timer1_high_byte(t1h),
    .o_timer0_overflow_flag(f0), .o_timer1_overflow_flag(f1), .o_timer0_irq(q0), .o_timer1_irq(q1),
    .o_timer1_baud_tick(baud)
  );
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // writes low then high byte of one timer
  task automatic wr16(input logic t, input logic [15:0] v);
    cw = 1'b1;
    sel = {t, 1'b0};
    wd = v[7:0];
    @(negedge clk);
    sel = {t, 1'b1};
    wd = v[15:8];
    @(negedge clk);
    cw = 1'b0;
    @(negedge clk);
  endtask
  task automatic clr(input logic [1:0] k);
    fw = 1'b1;
    fwd = ~k;
    @(negedge clk);
    fw = 1'b0;
  endtask
  task automatic pulse;
    repeat (6) @(negedge clk);
    fire = 2'h3;
    @(negedge clk);
    fire = 2'h0;
    repeat (8) @(negedge clk);
  endtask
  task automatic sc_wrap;
    timer_mode_reg = 8'h31;
    ie = 2'h1;
    wr16(1'b0, 16'hffff);
    run[0] = 1'b1;
    @(negedge clk);
    run[0] = 1'b0;
    chk("t0 wrap", 16'h0, {t0h, t0l});
    chk("t0 flag irq", 16'h3, {f0, q0});
    ie = 2'h0;
    @(negedge clk);
    chk("t0 irq masked", 16'h2, {f0, q0});
    ack[0] = 1'b1;
    @(negedge clk);
    ack[0] = 1'b0;
    chk("t0 flag ack", 16'h0, {f0, q0});
  endtask
  task automatic sc_modes;
    timer_mode_reg = 8'h30;
    wr16(1'b0, 16'hff1f);
    run[0] = 1'b1;
    @(negedge clk);
    run[0] = 1'b0;
    chk("t0 13-bit", 16'h1, {t0h, t0l[4:0], f0});
    clr(2'h1);
    chk("t0 flag wr", 16'h0, f0);
    timer_mode_reg = 8'h32;
    wr16(1'b0, 16'hf0fe);
    run[0] = 1'b1;
    repeat (2) @(negedge clk);
    run[0] = 1'b0;
    chk("t0 reload", 17'h1f0f0, {f0, t0h, t0l});
    clr(2'h1);
  endtask
  task automatic sc_prescale;
    timer_mode_reg = 8'h31;
    sys = 2'h0;
    for (int k = 0; k < 4; k++)
    begin
      cds = k[1:0];
      wr16(1'b0, 16'h0);
      repeat (64) @(negedge clk);
      run[0] = 1'b1;
      repeat (2 * div[k]) @(negedge clk);
      run[0] = 1'b0;
      chk("prescaled count", 16'h2, {t0h, t0l});
    end
    sys = 2'h3;
  endtask
  task automatic sc_pins;
    timer_mode_reg = 8'hdd;
    pol = 2'h1;
    run = 2'h3;
    wr16(1'b0, 16'h0);
    wr16(1'b1, 16'h0);
    pulse;
    chk("gated pins a", 16'h0001, {t0l, t1l});
    gate = 2'h3;
    pulse;
    chk("gated pins b", 16'h0101, {t0l, t1l});
    gate = 2'h1;
    pulse;
    chk("pin edges", 16'h0202, {t0l, t1l});
    run = 2'h0;
  endtask
  task automatic sc_split;
    timer_mode_reg = 8'h33;
    wr16(1'b0, 16'hff00);
    wr16(1'b1, 16'hffff);
    clr(2'h3);
    timer_mode_reg = 8'h13;
    @(negedge clk);
    run = 2'h3;
    chk("split t1 wrap", 16'h1ff, {f1, baud, t0h});
    chk("t1 free run", 16'h0, {t1h, t1l});
    @(negedge clk);
    timer_mode_reg = 8'h33;
    run = 2'h0;
    chk("split high", 17'h10001, {f1, t0h, t1l});
    chk("split low", 16'h1, t0l);
    ie = 2'h2;
    @(negedge clk);
    chk("t1 flag irq", 16'h3, {f1, q1});
    ack[1] = 1'b1;
    @(negedge clk);
    ack[1] = 1'b0;
    chk("t1 flag ack", 16'h0, {f1, q1});
    repeat (3) @(negedge clk);
    chk("t1 stopped", 16'h0001, {t1h, t1l});
  endtask
  initial
  begin
    repeat (5) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    sc_wrap;
    sc_modes;
    sc_prescale;
    sc_pins;
    sc_split;
    close_out;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    close_out;
  end
endmodule
`default_nettype wire
